/* File: logic/srd_pkg.sv */
// Shared constants and types for the sync-pulse and down-converter control.
// Assumes a single device clock at the rate given by CLK_PERIOD_NS.
package srd_pkg;

  // Device clock period in nanoseconds (10 MHz).
  localparam int CLK_PERIOD_NS = 100;
  // Delay-locked loop settling time in nanoseconds (40 us).
  localparam int DLL_TIME_NS = 40000;
  // Least settling time rounds up to whole cycles.
  localparam int DLL_CYCLES = (DLL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLL_CNT_W = $clog2(DLL_CYCLES + 1);

  // Sync assertion counter: saturates at this value.
  localparam logic [1:0] SYNC_COUNT_SAT = 2'h3;
  // Assertions already seen before the one that first resets NCO and LMFC.
  localparam logic [1:0] SYNC_IGNORED = 2'h2;
  localparam logic [1:0] SYNC_COUNT_RST = 2'h0;

  // Numerically controlled oscillator width and count.
  localparam int NCO_W = 16;
  localparam int NCO_NUM = 3;

  // Frames per multiframe multipliers in bypass layouts.
  localparam logic [15:0] BYP_WIDE_MULT = 16'h0014;
  localparam logic [15:0] BYP_NARROW_MULT = 16'h0004;

  // Filter refill depth, in decimated output samples, after a band switch.
  localparam logic [7:0] FLUSH_SAMPLES = 8'h40;
  // Interleave correction granularity in device clocks.
  localparam int INTERLEAVE_DIV = 64;

  // Down-converter configuration.
  typedef enum logic [1:0] {
    SRD_MODE_BYPASS,
    SRD_MODE_SINGLE,
    SRD_MODE_DUAL,
    SRD_MODE_WIDE
  } srd_mode_t;

  // Decimation ratio codes.
  typedef enum logic [3:0] {
    SRD_DEC_4, SRD_DEC_6, SRD_DEC_8, SRD_DEC_9, SRD_DEC_10, SRD_DEC_12,
    SRD_DEC_16, SRD_DEC_18, SRD_DEC_20, SRD_DEC_24, SRD_DEC_32
  } srd_dec_t;

  // Ratio for a decimation code; an illegal code falls back to four.
  function automatic logic [5:0] srd_dec_ratio(input logic [3:0] code);
    case (code)
      SRD_DEC_4: srd_dec_ratio = 6'h04;
      SRD_DEC_6: srd_dec_ratio = 6'h06;
      SRD_DEC_8: srd_dec_ratio = 6'h08;
      SRD_DEC_9: srd_dec_ratio = 6'h09;
      SRD_DEC_10: srd_dec_ratio = 6'h0a;
      SRD_DEC_12: srd_dec_ratio = 6'h0c;
      SRD_DEC_16: srd_dec_ratio = 6'h10;
      SRD_DEC_18: srd_dec_ratio = 6'h12;
      SRD_DEC_20: srd_dec_ratio = 6'h14;
      SRD_DEC_24: srd_dec_ratio = 6'h18;
      SRD_DEC_32: srd_dec_ratio = 6'h20;
      default: srd_dec_ratio = 6'h04;
    endcase
  endfunction

  // Active serial lanes per channel for a decimation ratio.
  function automatic logic [2:0] srd_lanes(input logic [5:0] ratio);
    if (ratio <= 6'h06) begin
      srd_lanes = 3'h4;
    end else if (ratio <= 6'h0c) begin
      srd_lanes = 3'h2;
    end else begin
      srd_lanes = 3'h1;
    end
  endfunction

endpackage

/* File: logic/srd_nco_bank.sv */
// Bank of free-running phase accumulators for the down-converter mixers.
// Assumes the frequency words are steady in the device clock domain.
`timescale 1ns/1ps

module srd_nco_bank #(
  parameter int NUM = srd_pkg::NCO_NUM,
  parameter int W = srd_pkg::NCO_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic phase_reset,
  input wire logic [W-1:0] fcw0,
  input wire logic [W-1:0] fcw1,
  input wire logic [W-1:0] fcw2,
  input wire logic [1:0] sel,
  output logic [W-1:0] phase
);
  import srd_pkg::*;

  logic [W-1:0] acc_q [NUM];
  logic [W-1:0] fcw [NUM];

  assign fcw[0] = fcw0;
  assign fcw[1] = fcw1;
  assign fcw[2] = fcw2;

  // Every accumulator runs all the time so a switch back keeps phase.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM; i++) begin
        acc_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM; i++) begin
        acc_q[i] <= phase_reset ? '0 : acc_q[i] + fcw[i];
      end
    end
  end

  // Registered mixer phase of the chosen accumulator.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= '0;
    end else begin
      phase <= acc_q[(sel >= 2'(NUM)) ? 2'(NUM - 1) : sel];
    end
  end

endmodule // srd_nco_bank

/* File: logic/srd_sync_ddc_ctrl.sv */
// Sync-pulse handling and down-converter mode control for one channel.
// Assumes all configuration inputs come from registers on clk; the sync
// pin and the oscillator select pins are asynchronous.
//
// Overview of operation
// - With divider mask set, sync pulses never reset the clock divider.
// - NCO phase and LMFC reset from the third assertion; first two ignored.
// - With oscillator mask set, sync no longer reaches NCO or LMFC.
// - LMFC period is 20K, 4K or D*S*K device clocks by mode.
// - Converter supports receiver single/dual band and wideband observation.
// - Two chains per channel, each with filter and 16-bit oscillator mixer.
// - Outside bypass, exactly one of single, dual or wideband configuration is active.
// - Optional real output at twice complex rate, mixed by fOUT/4.
// - Receiver mode chains share one decimation setting.
// - Decimation setting sets lane rate and number of active lanes.
// - Wideband chain switches among three oscillators by pins or command.
// - Oscillators run continuously; output invalid until filters refill.
// - Sync buffer power-down blocks the sync input.
// - Assertion is pin rising edge or software bit 0-to-1 change.
// - Every unmasked assertion resets the input clock divider.
`timescale 1ns/1ps

module srd_sync_ddc_ctrl (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sysref_pin,
  input wire logic software_sync_assert,
  input wire logic sysref_buffer_powerdown,
  input wire logic divider_sync_mask,
  input wire logic oscillator_frame_sync_mask,
  input wire srd_pkg::srd_mode_t mode,
  input wire logic [3:0] dec_code,
  input wire logic bypass_narrow,
  input wire logic [4:0] frames_per_multiframe,
  input wire logic [1:0] samples_per_frame,
  input wire logic real_out_en,
  input wire logic [15:0] fcw_a,
  input wire logic [15:0] fcw_b,
  input wire logic [15:0] fcw_w0,
  input wire logic [15:0] fcw_w1,
  input wire logic [15:0] fcw_w2,
  input wire logic osc_sel_from_pins,
  input wire logic [1:0] osc_sel_cmd,
  input wire logic [1:0] osc_sel_pins,
  output logic divider_reset,
  output logic nco_phase_reset,
  output logic lmfc_reset,
  output logic [1:0] sync_count,
  output logic dll_settled,
  output logic chain_a_en,
  output logic chain_b_en,
  output logic wide_en,
  output logic [5:0] dec_ratio,
  output logic [2:0] lane_count,
  output logic [8:0] lane_rate_div,
  output logic [15:0] lmfc_period,
  output logic lmfc_edge,
  output logic sample_strobe,
  output logic [1:0] real_mix_quadrant,
  output logic [1:0] active_osc,
  output logic data_valid,
  output logic [15:0] phase_a,
  output logic [15:0] phase_b,
  output logic [15:0] phase_w
);
  import srd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Sync input capture.

  logic pin_s1_q, pin_s2_q, pin_last_q, sw_last_q;
  logic [1:0] gp_s1_q, gp_s2_q;
  logic sync_evt;

  // Two-stage synchronisers for the asynchronous pins.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      gp_s1_q <= 2'h0;
      gp_s2_q <= 2'h0;
    end else begin
      pin_s1_q <= sysref_pin;
      pin_s2_q <= pin_s1_q;
      gp_s1_q <= osc_sel_pins;
      gp_s2_q <= gp_s1_q;
    end
  end

  // Edge history for the pin and the software bit.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_last_q <= 1'b0;
      sw_last_q <= 1'b0;
    end else begin
      pin_last_q <= pin_s2_q;
      sw_last_q <= software_sync_assert;
    end
  end

  // A buffer held powered down never yields a pin edge.
  assign sync_evt = (pin_s2_q & ~pin_last_q & ~sysref_buffer_powerdown) |
                    (software_sync_assert & ~sw_last_q);

  ////////////////////////////////////////////////////////////////////////////
  // Assertion counting and reset fan-out.

  logic [1:0] count_q;
  logic div_rst_q, nco_rst_q, lmfc_rst_q;

  // Saturating so later assertions keep acting like the third.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= SYNC_COUNT_RST;
    end else if (sync_evt && count_q != SYNC_COUNT_SAT) begin
      count_q <= count_q + 2'h1;
    end
  end

  // One-cycle reset pulses, registered to keep them glitch free.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_rst_q <= 1'b0;
      nco_rst_q <= 1'b0;
      lmfc_rst_q <= 1'b0;
    end else begin
      div_rst_q <= sync_evt & ~divider_sync_mask;
      nco_rst_q <= sync_evt & (count_q >= SYNC_IGNORED) &
                   ~oscillator_frame_sync_mask;
      lmfc_rst_q <= sync_evt & (count_q >= SYNC_IGNORED) &
                    ~oscillator_frame_sync_mask;
    end
  end

  assign divider_reset = div_rst_q;
  assign nco_phase_reset = nco_rst_q;
  assign lmfc_reset = lmfc_rst_q;
  assign sync_count = count_q;

  ////////////////////////////////////////////////////////////////////////////
  // Settling timer: tells software when the second pulse may be sent.

  logic [DLL_CNT_W-1:0] dll_cnt_q;

  // Starts at the first assertion; software may use it to pace pulses.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dll_cnt_q <= '0;
    end else if (sync_evt && count_q == SYNC_COUNT_RST) begin
      dll_cnt_q <= DLL_CNT_W'(DLL_CYCLES);
    end else if (dll_cnt_q != '0) begin
      dll_cnt_q <= dll_cnt_q - 1'b1;
    end
  end

  assign dll_settled = (count_q != SYNC_COUNT_RST) && (dll_cnt_q == '0);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration decode.

  logic [15:0] lmfc_period_d;
  logic [5:0] ratio;

  assign ratio = srd_dec_ratio(dec_code);

  // Exactly one configuration at a time; bypass enables none.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chain_a_en <= 1'b0;
      chain_b_en <= 1'b0;
      wide_en <= 1'b0;
      dec_ratio <= 6'h04;
      lane_count <= 3'h4;
      lane_rate_div <= 9'h010;
    end else begin
      chain_a_en <= (mode == SRD_MODE_SINGLE) || (mode == SRD_MODE_DUAL);
      chain_b_en <= (mode == SRD_MODE_DUAL);
      wide_en <= (mode == SRD_MODE_WIDE);
      dec_ratio <= ratio;
      lane_count <= srd_lanes(ratio);
      lane_rate_div <= 9'(ratio * srd_lanes(ratio));
    end
  end

  // Multiframe length in device clocks by layout and decimation.
  always_comb begin
    if (mode == SRD_MODE_BYPASS) begin
      lmfc_period_d = 16'((bypass_narrow ? BYP_NARROW_MULT : BYP_WIDE_MULT) *
                          16'(frames_per_multiframe));
    end else begin
      lmfc_period_d = 16'(ratio * 16'(samples_per_frame) *
                          16'(frames_per_multiframe));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local multiframe counter.

  logic [15:0] lmfc_cnt_q;

  // Realigned by the sync-driven reset so every multiframe edge lines up.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lmfc_cnt_q <= '0;
      lmfc_period <= '0;
      lmfc_edge <= 1'b0;
    end else begin
      lmfc_period <= lmfc_period_d;
      lmfc_edge <= lmfc_rst_q || (lmfc_cnt_q == 16'h0000);
      if (lmfc_rst_q || lmfc_cnt_q + 16'h0001 >= lmfc_period_d) begin
        lmfc_cnt_q <= '0;
      end else begin
        lmfc_cnt_q <= lmfc_cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock divider: output sample strobes, reset by the sync pulse.

  logic [5:0] div_q;
  logic [5:0] half;
  logic [1:0] quad_q;
  logic strobe_d;

  assign half = ratio >> 1;
  // Real output gives a second sample mid-way; odd ratios round down.
  assign strobe_d = (div_q == 6'h00) ||
                    (real_out_en && div_q == half);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= '0;
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= strobe_d;
      if (div_rst_q || div_q + 6'h01 >= ratio) begin
        div_q <= '0;
      end else begin
        div_q <= div_q + 6'h01;
      end
    end
  end

  // Quarter-rate mixing steps once per real sample.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      quad_q <= '0;
    end else if (!real_out_en || div_rst_q) begin
      quad_q <= '0;
    end else if (strobe_d) begin
      quad_q <= quad_q + 2'h1;
    end
  end

  assign real_mix_quadrant = quad_q;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator selection and refill tracking.

  logic [1:0] sel_q;
  logic [1:0] sel_d;
  logic [7:0] flush_q;

  assign sel_d = osc_sel_from_pins ? gp_s2_q : osc_sel_cmd;

  // Data are invalid until the filters have seen a full depth of new band.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_q <= '0;
      flush_q <= FLUSH_SAMPLES;
    end else begin
      sel_q <= sel_d;
      if (wide_en && sel_d != sel_q) begin
        flush_q <= FLUSH_SAMPLES;
      end else if (flush_q != 8'h00 && strobe_d) begin
        flush_q <= flush_q - 8'h01;
      end
    end
  end

  assign active_osc = sel_q;
  assign data_valid = (flush_q == 8'h00) &&
                      (chain_a_en || wide_en || mode == SRD_MODE_BYPASS);

  ////////////////////////////////////////////////////////////////////////////
  // Oscillators: two receiver chains and the three-way wideband chain.

  srd_nco_bank #(.NUM(NCO_NUM), .W(NCO_W)) u_wide (
    .clk(clk),
    .arst_n(arst_n),
    .phase_reset(nco_rst_q),
    .fcw0(fcw_w0),
    .fcw1(fcw_w1),
    .fcw2(fcw_w2),
    .sel(sel_q),
    .phase(phase_w)
  );

  srd_nco_bank #(.NUM(NCO_NUM), .W(NCO_W)) u_rx (
    .clk(clk),
    .arst_n(arst_n),
    .phase_reset(nco_rst_q),
    .fcw0(fcw_a),
    .fcw1(fcw_b),
    .fcw2(16'h0000),
    .sel(2'h0),
    .phase(phase_a)
  );

  srd_nco_bank #(.NUM(NCO_NUM), .W(NCO_W)) u_rx_b (
    .clk(clk),
    .arst_n(arst_n),
    .phase_reset(nco_rst_q),
    .fcw0(fcw_b),
    .fcw1(fcw_a),
    .fcw2(16'h0000),
    .sel(2'h0),
    .phase(phase_b)
  );

endmodule // srd_sync_ddc_ctrl

/* File: test/srd_sync_src.sv */
// Far-side sync source model: one clean pin pulse per request.
// Assumes the bench spaces requests by at least the settling gap.
`timescale 1ns/1ps

module srd_sync_src (
  input wire logic clk,
  input wire logic fire,
  output logic sysref_pin
);

  ////////////////////////////////////////////////////////////////////////
  // The pin idles low between pulses, as a disabled source does.
  initial sysref_pin = 1'h0;

  // Each request gives one rising edge held four cycles, long enough
  // for the two-stage synchroniser. The pulse rate stays far below the
  // coupling limit, but requests come 411 cycles apart, not on whole 320-cycle multiframes.
  // The pin moves 10 ns after a rising edge, like every bench input.
  always @(posedge fire) begin
    @(posedge clk);
    #10 sysref_pin = 1'h1;
    repeat (4) @(posedge clk);
    #10 sysref_pin = 1'h0;
  end

endmodule // srd_sync_src

/* File: test/srd_sync_ddc_ctrl_assertions.sv */
// Concurrent checks on the sync and down-converter control ports.
// Assumes one clock domain and a bench that holds mode steady in reset.
`timescale 1ns/1ps

module srd_ctrl_chk
  import srd_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic software_sync_assert,
  input wire logic divider_sync_mask,
  input wire logic oscillator_frame_sync_mask,
  input wire srd_pkg::srd_mode_t mode,
  input wire logic divider_reset,
  input wire logic nco_phase_reset,
  input wire logic lmfc_reset,
  input wire logic [1:0] sync_count,
  input wire logic chain_a_en,
  input wire logic chain_b_en,
  input wire logic wide_en,
  input wire logic [1:0] active_osc,
  input wire logic data_valid,
  input wire logic lmfc_edge,
  input wire logic [15:0] phase_a,
  input wire logic real_out_en,
  input wire logic sample_strobe,
  input wire logic [1:0] real_mix_quadrant
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////
  // Third software assertion with the oscillator path open.
  sequence s_third;
    $rose(software_sync_assert) && sync_count == 2'h2 &&
      !oscillator_frame_sync_mask;
  endsequence

  // After a phase reset the phase restarts at zero on a multiframe edge.
  sequence s_restart;
    phase_a == 16'h0 && lmfc_edge;
  endsequence

  a_div_mask_block: assert property (
    divider_reset |-> !$past(divider_sync_mask))
    else $error("divider reset while masked");
  a_sw_edge_div: assert property (
    $rose(software_sync_assert) && !divider_sync_mask |=> divider_reset)
    else $error("software edge gave no divider reset");
  a_nco_third: assert property (
    s_third |=> nco_phase_reset && lmfc_reset)
    else $error("third assertion gave no phase reset");
  a_nco_gate: assert property (
    nco_phase_reset |-> sync_count == 2'h3 &&
      !$past(oscillator_frame_sync_mask))
    else $error("phase reset too early or while masked");
  a_lmfc_pair: assert property (
    nco_phase_reset == lmfc_reset)
    else $error("phase and multiframe resets differ");
  // The accumulator clears one edge after the pulse, the mixer phase
  // register shows it one edge later still.
  a_nco_restart: assert property (
    nco_phase_reset |=> ##1 s_restart)
    else $error("phase did not restart");
  a_div_strobe: assert property (
    divider_reset |=> ##1 sample_strobe)
    else $error("divider reset did not realign strobe");
  a_quad_step: assert property (
    $past(real_out_en) && !$past(divider_reset) && sample_strobe |->
      real_mix_quadrant == $past(real_mix_quadrant) + 2'h1)
    else $error("real mix quadrant did not step");
  a_count_step: assert property (
    $changed(sync_count) |-> sync_count == $past(sync_count) + 2'h1)
    else $error("count moved by other than one");
  a_count_sat: assert property (
    sync_count == 2'h3 |=> sync_count == 2'h3)
    else $error("count left saturation");
  a_one_config: assert property (
    wide_en |-> !chain_a_en && !chain_b_en)
    else $error("wideband with receiver chain on");
  a_wide_mode: assert property (
    wide_en == ($past(mode) == SRD_MODE_WIDE))
    else $error("wideband enable does not follow mode");
  a_osc_flush: assert property (
    wide_en && $changed(active_osc) |-> !data_valid)
    else $error("data valid across oscillator switch");

endmodule // srd_ctrl_chk

bind srd_sync_ddc_ctrl srd_ctrl_chk u_chk (
  .clk, .arst_n, .software_sync_assert, .divider_sync_mask,
  .oscillator_frame_sync_mask, .mode, .divider_reset, .nco_phase_reset,
  .lmfc_reset, .sync_count, .chain_a_en, .chain_b_en, .wide_en,
  .active_osc, .data_valid, .lmfc_edge, .phase_a, .real_out_en,
  .sample_strobe, .real_mix_quadrant
);

/* File: test/tb.sv */
// Self-checking bench for the sync and down-converter control block.
// Assumes the source model on the pin and the bound port checker.
`timescale 1ns/1ps

module tb;
  import srd_pkg::*;

  logic clk = 1'h0, arst_n = 1'h0, fire = 1'h0, sysref_pin;
  logic software_sync_assert = 1'h0, sysref_buffer_powerdown = 1'h0;
  logic divider_sync_mask = 1'h0, oscillator_frame_sync_mask = 1'h0;
  srd_mode_t mode = SRD_MODE_BYPASS;
  logic [3:0] dec_code = 4'h0;
  logic bypass_narrow = 1'h0, real_out_en = 1'h0, osc_sel_from_pins = 1'h0;
  logic [4:0] frames_per_multiframe = 5'h10;
  logic [1:0] samples_per_frame = 2'h2, osc_sel_cmd = 2'h0;
  logic [1:0] osc_sel_pins = 2'h0, sync_count, active_osc;
  logic [15:0] fcw = 16'h1234, lmfc_period;
  logic divider_reset, nco_phase_reset, chain_a_en, chain_b_en, wide_en;
  logic data_valid, dll_settled;
  logic [15:0] phase_a, phase_b, phase_w;
  logic [5:0] dec_ratio;
  logic [2:0] lane_count;
  logic [8:0] lane_rate_div;
  int n_errors = 0, comparisons = 0;

  always #50 clk = ~clk;

  srd_sync_src u_src (.clk, .fire, .sysref_pin);

  srd_sync_ddc_ctrl uut (
    .clk, .arst_n, .sysref_pin, .software_sync_assert,
    .sysref_buffer_powerdown, .divider_sync_mask,
    .oscillator_frame_sync_mask, .mode, .dec_code, .bypass_narrow,
    .frames_per_multiframe, .samples_per_frame, .real_out_en,
    .fcw_a(fcw), .fcw_b(~fcw), .fcw_w0(fcw + 16'h0100),
    .fcw_w1(fcw + 16'h0200), .fcw_w2(fcw + 16'h0300),
    .osc_sel_from_pins, .osc_sel_cmd, .osc_sel_pins, .divider_reset,
    .nco_phase_reset, .lmfc_reset(), .sync_count, .dll_settled,
    .chain_a_en, .chain_b_en, .wide_en, .dec_ratio, .lane_count,
    .lane_rate_div, .lmfc_period, .lmfc_edge(), .sample_strobe(),
    .real_mix_quadrant(), .active_osc, .data_valid, .phase_a,
    .phase_b, .phase_w
  );

  ////////////////////////////////////////////////////////////////////////
  // Case equality so an unknown never passes.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Inputs always change a fixed 10 ns after the rising edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  // One software assertion; the answer stands one cycle after it.
  task automatic sw_pulse(input logic d, input logic n);
    software_sync_assert = 1'h1;
    step(1);
    chk(divider_reset, d);
    chk(nco_phase_reset, n);
    software_sync_assert = 1'h0;
    step(1);
  endtask

  // Counting, the third-pulse rule and both masks.
  task automatic t_sync;
    sw_pulse(1'h1, 1'h0);
    sw_pulse(1'h1, 1'h0);
    chk(sync_count, 16'h2);
    sw_pulse(1'h1, 1'h1);
    sw_pulse(1'h1, 1'h1);
    chk(sync_count, 16'h3);
    divider_sync_mask = 1'h1;
    sw_pulse(1'h0, 1'h1);
    oscillator_frame_sync_mask = 1'h1;
    sw_pulse(1'h0, 1'h0);
    divider_sync_mask = 1'h0;
    sw_pulse(1'h1, 1'h0);
    oscillator_frame_sync_mask = 1'h0;
  endtask

  // A pin pulse from the source; look for a divider reset in a window.
  task automatic pin_pulse(input logic exp);
    logic seen;
    seen = 1'h0;
    fire = 1'h1;
    step(1);
    fire = 1'h0;
    repeat (10) begin
      step(1);
      seen |= divider_reset;
    end
    chk(seen, exp);
  endtask

  task automatic t_mode(input srd_mode_t m, input logic [2:0] en);
    mode = m;
    step(2);
    chk({chain_a_en, chain_b_en, wide_en}, en);
  endtask

  task automatic t_lmfc(input srd_mode_t m, input logic nb,
                        input logic [15:0] exp);
    mode = m;
    bypass_narrow = nb;
    step(3);
    chk(lmfc_period, exp);
  endtask

  // Every decimation code, then an illegal one that falls back to four.
  task automatic t_dec;
    logic [5:0] r [11] = '{6'h04, 6'h06, 6'h08, 6'h09, 6'h0a, 6'h0c,
                           6'h10, 6'h12, 6'h14, 6'h18, 6'h20};
    logic [2:0] l;
    for (int i = 0; i < 11; i++) begin
      dec_code = 4'(i);
      step(3);
      l = r[i] <= 6'h06 ? 3'h4 : r[i] <= 6'h0c ? 3'h2 : 3'h1;
      chk(dec_ratio, r[i]);
      chk(lane_count, l);
      chk(lane_rate_div, r[i] * l);
    end
    dec_code = 4'hf;
    step(3);
    chk(dec_ratio, 16'h4);
    dec_code = 4'h0;
  endtask

  // Each oscillator advances by its own word every cycle.
  task automatic t_phase(input logic [1:0] s);
    logic [15:0] a, b, w;
    a = phase_a;
    b = phase_b;
    w = phase_w;
    step(1);
    chk(phase_a - a, fcw);
    chk(phase_b - b, ~fcw);
    chk(phase_w - w, fcw + {6'h00, s + 2'h1, 8'h00});
  endtask

  // Switch oscillator, then wait out the filter refill.
  task automatic t_osc(input logic pins, input logic [1:0] s,
                       input logic [1:0] exp);
    int n;
    osc_sel_from_pins = pins;
    osc_sel_pins = s;
    if (!pins) begin
      osc_sel_cmd = s;
    end
    n = 0;
    step(1);
    while (active_osc !== exp && n < 8) begin
      step(1);
      n++;
    end
    chk(active_osc, exp);
    chk(data_valid, 1'h0);
    n = 0;
    while (data_valid !== 1'h1 && n < 2000) begin
      step(1);
      n++;
    end
    chk(data_valid, 1'h1);
    chk(n >= 64, 1'h1);
    t_phase(exp);
  endtask

  task automatic print_verdict;
    $display("n_errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence; source pulses are spaced by the settling gap.
  initial begin
    step(2);
    arst_n = 1'h1;
    step(1);
    t_sync();
    chk(dll_settled, 1'h0);
    pin_pulse(1'h1);
    sysref_buffer_powerdown = 1'h1;
    step(DLL_CYCLES);
    chk(dll_settled, 1'h1);
    pin_pulse(1'h0);
    sysref_buffer_powerdown = 1'h0;
    step(DLL_CYCLES);
    pin_pulse(1'h1);
    t_mode(SRD_MODE_BYPASS, 3'h0);
    t_mode(SRD_MODE_SINGLE, 3'h4);
    t_mode(SRD_MODE_DUAL, 3'h6);
    t_mode(SRD_MODE_WIDE, 3'h1);
    t_lmfc(SRD_MODE_BYPASS, 1'h0, 16'h0140);
    t_lmfc(SRD_MODE_BYPASS, 1'h1, 16'h0040);
    t_lmfc(SRD_MODE_DUAL, 1'h0, 16'h0080);
    t_dec();
    t_mode(SRD_MODE_WIDE, 3'h1);
    step(300);
    t_osc(1'h0, 2'h1, 2'h1);
    t_osc(1'h0, 2'h2, 2'h2);
    real_out_en = 1'h1;
    t_osc(1'h1, 2'h0, 2'h0);
    print_verdict();
  end

endmodule // tb
